// [hw/atou_map.vh]
// Register map, reset values and widths for the alert triggered output update block
`ifndef ATOU_MAP_VH
`define ATOU_MAP_VH

// Data, channel and address widths
`define ATOU_DW 8
`define ATOU_NOUT 8
`define ATOU_AW 8

// Per-output trigger source mask addresses
`define ATOU_ADDR_MASK0 8'hC3
`define ATOU_ADDR_MASK1 8'hC5
`define ATOU_ADDR_MASK2 8'hC7
`define ATOU_ADDR_MASK3 8'hC9
`define ATOU_ADDR_MASK4 8'hCB
`define ATOU_ADDR_MASK5 8'hCD
`define ATOU_ADDR_MASK6 8'hCF
`define ATOU_ADDR_MASK7 8'hD1

// Trigger update enable and preset level registers
`define ATOU_ADDR_TRIG_EN 8'hE9
`define ATOU_ADDR_PRESET 8'hEB

// Read-only view of the present output levels
`define ATOU_ADDR_OUT_STATE 8'hF1

// Reset values
`define ATOU_RST_MASK 8'h02
`define ATOU_RST_TRIG_EN 8'h00
`define ATOU_RST_PRESET 8'h00
`define ATOU_RST_OUT 1'h0
`define ATOU_RST_BYTE 8'h00

// Answer to an unmapped read
`define ATOU_UNMAPPED_RD 8'h00

`endif

// [hw/atou_cfg_reg.v]
// One byte-wide software configuration register with a fixed reset value
`timescale 1ns/10ps
`include "atou_map.vh"

module atou_cfg_reg #(
  parameter [`ATOU_DW-1:0] RST_VAL = `ATOU_RST_BYTE
) (
  input wire mclk,
  input wire rst,
  input wire wrEn,
  input wire [`ATOU_DW-1:0] wrData,
  output wire [`ATOU_DW-1:0] q
);

  reg [`ATOU_DW-1:0] val_ff; // Stored byte

  // Async reset loads the constant, a write replaces the whole byte
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      val_ff <= RST_VAL;
    end else if (wrEn) begin
      val_ff <= wrData;
    end
  end

  assign q = val_ff;

endmodule // atou_cfg_reg

// [hw/atou_out_slice.v]
// Trigger detection and level register for one general digital output
`timescale 1ns/10ps
`include "atou_map.vh"

module atou_out_slice (
  input wire mclk,
  input wire rst,
  input wire [`ATOU_NOUT-1:0] alertFlags,
  input wire [`ATOU_NOUT-1:0] srcMask,
  input wire trigEn,
  input wire presetLevel,
  input wire swLoad,
  input wire swLevel,
  output wire levelOut,
  output wire trigPulse
);

  reg condPrev_ff; // Condition seen last cycle
  reg level_ff; // Driven output level
  reg trig_ff; // One-cycle trigger marker
  wire cond; // Masked OR of alert flags
  wire condRise; // Condition newly true

  // Only channels whose mask bit is one take part, analog or digital alike
  assign cond = |(alertFlags & srcMask); // [R1] [R2] [R12]
  assign condRise = cond & ~condPrev_ff; // [R12]

  // Edge memory runs even while disabled, so enabling never fires on a stale flag
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      condPrev_ff <= `ATOU_RST_OUT;
    end else begin
      condPrev_ff <= cond;
    end
  end

  // Trigger wins over a plain software write in the same cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      level_ff <= `ATOU_RST_OUT;
      trig_ff <= `ATOU_RST_OUT;
    end else begin
      trig_ff <= trigEn & condRise; // [R5] [R6]
      if (trigEn && condRise) begin
        // Preset bit gives the level directly
        level_ff <= presetLevel; // [R5] [R10] [R12]
      end else if (swLoad) begin
        // Ordinary software value
        level_ff <= swLevel;
      end
      // Disabled: alerts leave the level alone
    end
  end

  assign levelOut = level_ff;
  assign trigPulse = trig_ff;

endmodule // atou_out_slice

// [hw/atou_top.v]
// Alert triggered update logic for the eight general digital outputs
//
// Contract
// [R1] Mask bit one lets that channel trigger
// [R2] Analog and digital channel alerts both count
// [R3] Every selection mask resets to binary 10
// [R4] Masks four to seven at CB CD CF D1
// [R5] Enabled output updates when selected alert sets
// [R6] Disabled output ignores all alert flags
// [R7] Software programs mask when enabling trigger update
// [R8] Enable register at E9, resets to zero
// [R9] Preset level register at EB, resets zero
// [R10] Trigger drives output to its preset bit
// [R11] Masks zero to two at C3 C5 C7
// [R12] Masked OR; output set next cycle
`timescale 1ns/10ps
`include "atou_map.vh"

module atou_top (
  input wire mclk,
  input wire rst,
  input wire [`ATOU_AW-1:0] regAddr,
  input wire [`ATOU_DW-1:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output wire [`ATOU_DW-1:0] regRdData,
  output wire regRdValid,
  input wire [`ATOU_NOUT-1:0] alertFlags,
  input wire [`ATOU_NOUT-1:0] swOutLoad,
  input wire [`ATOU_NOUT-1:0] swOutValue,
  output wire [`ATOU_NOUT-1:0] generalDigitalOutput,
  output wire [`ATOU_NOUT-1:0] trigFired
);

  // Address table of the eight mask registers, output 0 in the low byte
  wire [`ATOU_NOUT*`ATOU_AW-1:0] maskAddrTab; // Packed addresses
  wire [`ATOU_NOUT*`ATOU_DW-1:0] maskBus; // Packed mask values
  wire [`ATOU_NOUT-1:0] maskWrEn; // Per-mask write strobe
  wire [`ATOU_DW-1:0] triggerUpdateEnableBits; // Per-output enable
  wire [`ATOU_DW-1:0] presetLevelBits; // Per-output preset level
  wire trigEnWr; // Enable register write
  wire presetWr; // Preset register write
  reg [`ATOU_DW-1:0] rdData_ff; // Read answer
  reg rdValid_ff; // Read answer marker
  reg [`ATOU_DW-1:0] nxt_rdData; // Read mux result

  // Printed mask offsets, kept in one table so decode can loop
  assign maskAddrTab = {`ATOU_ADDR_MASK7, `ATOU_ADDR_MASK6,
                        `ATOU_ADDR_MASK5, `ATOU_ADDR_MASK4, // [R4]
                        `ATOU_ADDR_MASK3, `ATOU_ADDR_MASK2,
                        `ATOU_ADDR_MASK1, `ATOU_ADDR_MASK0}; // [R11]

  // Full-byte compare; writes to any other address are dropped silently
  assign trigEnWr = regWrEn & (regAddr == `ATOU_ADDR_TRIG_EN); // [R8]
  assign presetWr = regWrEn & (regAddr == `ATOU_ADDR_PRESET); // [R9]

  // Output 0: mask decode, mask register with only channel 1 selected, trigger slice
  assign maskWrEn[0] = regWrEn & (regAddr == maskAddrTab[0*`ATOU_AW +: `ATOU_AW]); // [R11]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask0 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[0]),
    .wrData(regWrData),
    .q(maskBus[0*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice0 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[0*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[0]),
    .presetLevel(presetLevelBits[0]),
    .swLoad(swOutLoad[0]),
    .swLevel(swOutValue[0]),
    .levelOut(generalDigitalOutput[0]),
    .trigPulse(trigFired[0])
  );

  // Output 1: same structure, own mask address
  assign maskWrEn[1] = regWrEn & (regAddr == maskAddrTab[1*`ATOU_AW +: `ATOU_AW]); // [R11]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask1 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[1]),
    .wrData(regWrData),
    .q(maskBus[1*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice1 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[1*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[1]),
    .presetLevel(presetLevelBits[1]),
    .swLoad(swOutLoad[1]),
    .swLevel(swOutValue[1]),
    .levelOut(generalDigitalOutput[1]),
    .trigPulse(trigFired[1])
  );

  // Output 2: same structure, own mask address
  assign maskWrEn[2] = regWrEn & (regAddr == maskAddrTab[2*`ATOU_AW +: `ATOU_AW]); // [R11]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask2 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[2]),
    .wrData(regWrData),
    .q(maskBus[2*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice2 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[2*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[2]),
    .presetLevel(presetLevelBits[2]),
    .swLoad(swOutLoad[2]),
    .swLevel(swOutValue[2]),
    .levelOut(generalDigitalOutput[2]),
    .trigPulse(trigFired[2])
  );

  // Output 3: address sits between its neighbours, same structure
  assign maskWrEn[3] = regWrEn & (regAddr == maskAddrTab[3*`ATOU_AW +: `ATOU_AW]);
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask3 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[3]),
    .wrData(regWrData),
    .q(maskBus[3*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice3 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[3*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[3]),
    .presetLevel(presetLevelBits[3]),
    .swLoad(swOutLoad[3]),
    .swLevel(swOutValue[3]),
    .levelOut(generalDigitalOutput[3]),
    .trigPulse(trigFired[3])
  );

  // Output 4: same structure, own mask address
  assign maskWrEn[4] = regWrEn & (regAddr == maskAddrTab[4*`ATOU_AW +: `ATOU_AW]); // [R4]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask4 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[4]),
    .wrData(regWrData),
    .q(maskBus[4*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice4 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[4*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[4]),
    .presetLevel(presetLevelBits[4]),
    .swLoad(swOutLoad[4]),
    .swLevel(swOutValue[4]),
    .levelOut(generalDigitalOutput[4]),
    .trigPulse(trigFired[4])
  );

  // Output 5: same structure, own mask address
  assign maskWrEn[5] = regWrEn & (regAddr == maskAddrTab[5*`ATOU_AW +: `ATOU_AW]); // [R4]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask5 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[5]),
    .wrData(regWrData),
    .q(maskBus[5*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice5 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[5*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[5]),
    .presetLevel(presetLevelBits[5]),
    .swLoad(swOutLoad[5]),
    .swLevel(swOutValue[5]),
    .levelOut(generalDigitalOutput[5]),
    .trigPulse(trigFired[5])
  );

  // Output 6: same structure, own mask address
  assign maskWrEn[6] = regWrEn & (regAddr == maskAddrTab[6*`ATOU_AW +: `ATOU_AW]); // [R4]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask6 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[6]),
    .wrData(regWrData),
    .q(maskBus[6*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice6 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[6*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[6]),
    .presetLevel(presetLevelBits[6]),
    .swLoad(swOutLoad[6]),
    .swLevel(swOutValue[6]),
    .levelOut(generalDigitalOutput[6]),
    .trigPulse(trigFired[6])
  );

  // Output 7: last mask, same structure
  assign maskWrEn[7] = regWrEn & (regAddr == maskAddrTab[7*`ATOU_AW +: `ATOU_AW]); // [R4]
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_MASK) // [R3]
  ) uMask7 (
    .mclk(mclk),
    .rst(rst),
    .wrEn(maskWrEn[7]),
    .wrData(regWrData),
    .q(maskBus[7*`ATOU_DW +: `ATOU_DW])
  );
  atou_out_slice uSlice7 (
    .mclk(mclk),
    .rst(rst),
    .alertFlags(alertFlags),
    .srcMask(maskBus[7*`ATOU_DW +: `ATOU_DW]),
    .trigEn(triggerUpdateEnableBits[7]),
    .presetLevel(presetLevelBits[7]),
    .swLoad(swOutLoad[7]),
    .swLevel(swOutValue[7]),
    .levelOut(generalDigitalOutput[7]),
    .trigPulse(trigFired[7])
  );

  // Enable bits, all off after reset so no output moves on its own
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_TRIG_EN) // [R8]
  ) uTrigEn (
    .mclk(mclk),
    .rst(rst),
    .wrEn(trigEnWr),
    .wrData(regWrData),
    .q(triggerUpdateEnableBits)
  );

  // Preset levels, all low after reset
  atou_cfg_reg #(
    .RST_VAL(`ATOU_RST_PRESET) // [R9]
  ) uPreset (
    .mclk(mclk),
    .rst(rst),
    .wrEn(presetWr),
    .wrData(regWrData),
    .q(presetLevelBits)
  );

  // Read mux; the output-state view lets software see trigger results
  always @* begin
    nxt_rdData = `ATOU_UNMAPPED_RD;
    case (regAddr)
      `ATOU_ADDR_MASK0: begin
        nxt_rdData = maskBus[0*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK1: begin
        nxt_rdData = maskBus[1*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK2: begin
        nxt_rdData = maskBus[2*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK3: begin
        nxt_rdData = maskBus[3*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK4: begin
        nxt_rdData = maskBus[4*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK5: begin
        nxt_rdData = maskBus[5*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK6: begin
        nxt_rdData = maskBus[6*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_MASK7: begin
        nxt_rdData = maskBus[7*`ATOU_DW +: `ATOU_DW];
      end
      `ATOU_ADDR_TRIG_EN: begin
        nxt_rdData = triggerUpdateEnableBits;
      end
      `ATOU_ADDR_PRESET: begin
        nxt_rdData = presetLevelBits;
      end
      `ATOU_ADDR_OUT_STATE: begin
        nxt_rdData = generalDigitalOutput;
      end
      default: begin
        // Unmapped reads answer zero
        nxt_rdData = `ATOU_UNMAPPED_RD;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_ff <= `ATOU_RST_BYTE;
      rdValid_ff <= `ATOU_RST_OUT;
    end else begin
      rdValid_ff <= regRdEn;
      if (regRdEn) begin
        // Data holds until the next read
        rdData_ff <= nxt_rdData;
      end
    end
  end

  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;

endmodule // atou_top

// [sim/atou_props.sv]
// Assertion checker for the alert triggered output update block
`timescale 1ns/10ps
`include "atou_map.vh"
module atou_props (
  input wire mclk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire regRdValid,
  input wire [7:0] alertFlags,
  input wire [7:0] swOutLoad,
  input wire [7:0] swOutValue,
  input wire [7:0] generalDigitalOutput,
  input wire [7:0] trigFired
);
  // One domain, reset masks every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Read strobe with an idle cycle after it
  sequence sLoneRd;
    regRdEn ##1 !regRdEn;
  endsequence
  a_rd_answer: assert property (regRdEn |=> regRdValid)
    else $error("no read answer");
  a_rd_lone: assert property (sLoneRd |=> !regRdValid)
    else $error("read answer too long");
  a_rd_hold: assert property (!$past(regRdEn) |-> $stable(regRdData))
    else $error("read data moved");
  a_unmapped_zero: assert property (regRdEn && regAddr == 8'h00 |=> regRdData == `ATOU_UNMAPPED_RD)
    else $error("unmapped read not zero");
  a_fire_single: assert property ((trigFired & $past(trigFired)) == 8'h00)
    else $error("trigger pulse too long");
  a_fire_cause: assert property (|trigFired |-> |$past(alertFlags))
    else $error("trigger without alert");
  a_out_cause: assert property (
    ((generalDigitalOutput ^ $past(generalDigitalOutput)) & ~(trigFired | $past(swOutLoad))) == 8'h00)
    else $error("output moved alone");
  a_sw_load: assert property (
    ((generalDigitalOutput ^ $past(swOutValue)) & $past(swOutLoad) & ~trigFired) == 8'h00)
    else $error("software load lost");
endmodule // atou_props

bind atou_top atou_props u_props (.mclk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .regRdValid, .alertFlags, .swOutLoad, .swOutValue, .generalDigitalOutput, .trigFired);

// [sim/atou_out_sink.sv]
// Receiver model latching the general digital outputs
`timescale 1ns/10ps
module atou_out_sink (
  input wire mclk,
  input wire [7:0] lvl,
  output logic [7:0] seen
);
  // Far side samples pins on the rising edge, no reset
  always @(posedge mclk) begin
    seen <= lvl;
  end
endmodule // atou_out_sink

// [sim/alert_triggered_output_update_tb_top.sv]
// Self-checking bench for the alert triggered output update block
`timescale 1ns/10ps
`include "atou_map.vh"
module alert_triggered_output_update_tb_top;
  logic mclk, rst, regWrEn, regRdEn; // Clock, reset, strobes
  logic [7:0] regAddr, regWrData, alertFlags, swOutLoad, swOutValue; // Driven inputs
  wire [7:0] regRdData, generalDigitalOutput, trigFired, seen; // Observed outputs
  wire regRdValid; // Read answer strobe
  logic [7:0] expOut; // Expected pin levels
  logic [31:0] seed = 32'h2FA0; // Fixed random seed
  logic [7:0] rq[$]; // Pending read notes
  logic [15:0] tq[$]; // Pending trigger notes
  int error_cnt = 0;
  int n_checks = 0;
  atou_top uut (.mclk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid,
    .alertFlags, .swOutLoad, .swOutValue, .generalDigitalOutput, .trigFired);
  atou_out_sink sink (.mclk, .lvl(generalDigitalOutput), .seen);
  // 100 MHz clock
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Drive just after the edge so sampling never races
  task stp();
    @(posedge mclk) #1;
  endtask
  task chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Idle cycle after each strobe keeps one driver per step
  task wr(input logic [7:0] a, d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    stp();
    regWrEn = 0;
    stp();
  endtask
  task rd(input logic [7:0] a, e);
    rq.push_back(e);
    regAddr = a;
    regRdEn = 1;
    stp();
    regRdEn = 0;
    stp();
  endtask
  task final_report();
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Oldest note against each answer; unexpected fires count as errors
  always @(posedge mclk) begin
    #1;
    if (regRdValid === 1'b1)
      chk("read", {8'h00, regRdData}, {8'h00, rq.pop_front()});
    if (trigFired !== 8'h00 && tq.size() == 0)
      chk("stray fire", {trigFired, generalDigitalOutput}, 16'h0000);
    else if (trigFired !== 8'h00)
      chk("fire", {trigFired, generalDigitalOutput}, tq.pop_front());
  end
  // Hang guard, far beyond the fewer than two hundred cycles needed
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    int i;
    logic [7:0] ma, ch, v;
    {regWrEn, regRdEn, regAddr, regWrData, alertFlags, swOutLoad, swOutValue} = '0;
    expOut = 8'h00;
    rst = 1;
    repeat (5) @(posedge mclk);
    #1 rst = 0;
    rd(8'h00, 8'h00);
    rd(`ATOU_ADDR_TRIG_EN, 8'h00);
    rd(`ATOU_ADDR_PRESET, 8'h00);
    for (i = 0; i < 8; i++) begin
      ma = `ATOU_ADDR_MASK0 + 8'(2 * i);
      rd(ma, `ATOU_RST_MASK);
      seed = xs(seed);
      ch = 8'h01 << seed[2:0];
      v = seed[15:8];
      wr(ma, ch);
      rd(ma, ch);
      wr(`ATOU_ADDR_PRESET, v);
      wr(`ATOU_ADDR_TRIG_EN, 8'h01 << i);
      alertFlags = ~ch;
      stp();
      expOut[i] = v[i];
      tq.push_back({8'h01 << i, expOut});
      alertFlags = 8'hFF;
      stp();
      chk("latency", {8'h00, trigFired}, {8'h00, 8'h01 << i});
      alertFlags = 8'h00;
      wr(`ATOU_ADDR_TRIG_EN, 8'h00);
      alertFlags = ch;
      wr(`ATOU_ADDR_PRESET, ~v);
      alertFlags = 8'h00;
      rd(`ATOU_ADDR_OUT_STATE, expOut);
    end
    // Software load, then a write to the read-only view
    seed = xs(seed);
    swOutValue = seed[7:0];
    swOutLoad = seed[15:8];
    stp();
    expOut = (expOut & ~swOutLoad) | (swOutValue & swOutLoad);
    swOutLoad = 8'h00;
    wr(`ATOU_ADDR_OUT_STATE, ~expOut);
    rd(`ATOU_ADDR_OUT_STATE, expOut);
    // Reset in mid-run restores defaults
    rst = 1;
    stp();
    rst = 0;
    expOut = 8'h00;
    rd(`ATOU_ADDR_MASK7, `ATOU_RST_MASK);
    rd(`ATOU_ADDR_TRIG_EN, 8'h00);
    chk("sink", {8'h00, seen}, {8'h00, expOut});
    final_report();
  end
endmodule // alert_triggered_output_update_tb_top
